// ### wwr_pkg.sv
// shared constants, types and bus carriers of the windowed watchdog block
package wwr_pkg;

	// ----------------------------------------------------------------
	// register map: word index, byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [2:0] CFG_IDX  = 3'h0;   // timeout_config
	localparam logic [2:0] STAT_IDX = 3'h1;   // lock_and_sync_state
	localparam logic [2:0] IST_IDX  = 3'h2;   // interrupt status, write one to clear
	localparam logic [2:0] IMSK_IDX = 3'h3;   // interrupt mask
	localparam logic [2:0] KEY_IDX  = 3'h4;   // change_protection key
	localparam logic [2:0] LAST_IDX = 3'h4;   // highest mapped index

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned PER_LSB  = 0;     // time-out field 3:0
	localparam int unsigned WIN_LSB  = 4;     // window field 7:4
	localparam int unsigned LOCK_BIT = 7;     // lock in status
	localparam int unsigned BUSY_BIT = 0;     // sync_pending in status
	localparam logic [7:0]  STAT_RESET = 8'h00;
	localparam logic [7:0]  CFG_RESET  = 8'h00;  // until the fuse is caught
	localparam logic [3:0]  MAX_CODE   = 4'hB;   // largest valid period code

	// ----------------------------------------------------------------
	// interrupt events
	// ----------------------------------------------------------------
	localparam int unsigned IRQ_W      = 3;
	localparam int unsigned EV_TIMEOUT = 0;   // reset issued by expiry
	localparam int unsigned EV_EARLY   = 1;   // reset issued by early clear
	localparam int unsigned EV_SYNC    = 2;   // config reached slow domain

	// ----------------------------------------------------------------
	// counts
	// ----------------------------------------------------------------
	localparam int unsigned CNT_W             = 15;    // holds 8192 + margin
	localparam logic [14:0] BASE_TICKS        = 15'h0008; // code one period
	localparam logic [1:0]  SYNC_TICKS        = 2'h2;  // slow ticks per config transfer
	localparam logic [1:0]  CLR_TICKS         = 2'h2;  // slow ticks per clear
	localparam logic [2:0]  UNLOCK_WIN_CYCLES = 3'h4;  // unlock lifetime in ref_clk cycles
	localparam logic [7:0]  UNLOCK_KEY        = 8'h5A; // arbitrary key value
	localparam logic [1:0]  RESP_OKAY         = 2'h0;
	localparam logic [1:0]  RESP_SLVERR       = 2'h2;

	// watchdog phase, one-hot
	typedef enum logic [1:0] {
		PH_OPEN   = 2'b01,
		PH_CLOSED = 2'b10
	} wwr_phase_e;

	// axi4-lite master to slave
	typedef struct packed {
		logic        awvalid;
		logic [31:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [31:0] araddr;
		logic        rready;
	} wwr_axi_req_s;

	// axi4-lite slave to master
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} wwr_axi_rsp_s;

endpackage

// ### wwr_tick_sync.sv
// synchroniser and rising-edge detector for the slow oscillator clock
`timescale 1ns/1ps
module wwr_tick_sync (
	input  wire logic ref_clk,
	input  wire logic arst_n,
	input  wire logic ce,
	input  wire logic async_i,
	output logic      rise_o
);
	import wwr_pkg::*;

	typedef struct packed {
		logic s1;   // metastable stage, read only by s2
		logic s2;   // settled level
		logic s3;   // delayed level for edge detection
	} wwr_sync_s;

	wwr_sync_s q;   // registered state
	wwr_sync_s d;   // next state

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		d    = q;
		d.s1 = async_i;
		d.s2 = q.s1;
		d.s3 = q.s2;
	end

	// ----------------------------------------------------------------
	// registers, frozen while ce is low
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	// one ref_clk pulse per slow clock rising edge
	assign rise_o = q.s2 & ~q.s3;

endmodule

// ### wwr_watchdog.sv
// windowed watchdog with axi4-lite registers, lock and change protection
// Operation
// - nonzero time-out code enables, doubling periods
// - window mode: time-out code sets open length
// - nonzero window code selects closed-window operation
// - lock set makes both fields read-only
// - lock set by software or boot completion, only debug clears
// - boot completion with period nonzero sets lock
// - lock and config writes need prior unlock
// - config write raises pending while crossing domains
// - pending drops when transfer completes
// - config loaded from fuse at reset
// - normal mode: expiry without clear resets system
// - clear in closed window resets; first-clear start
// - clear syncs on the second tick, repeats ignored
`timescale 1ns/1ps
module wwr_watchdog #(
	parameter logic [14:0] BASE = wwr_pkg::BASE_TICKS  // slow ticks of code one
) (
	input  wire logic                 ref_clk,
	input  wire logic                 arst_n,
	input  wire logic                 ce,
	input  wire wwr_pkg::wwr_axi_req_s axi_req,
	output wwr_pkg::wwr_axi_rsp_s     axi_rsp,
	input  wire logic                 slow_oscillator_clock,
	input  wire logic [7:0]           boot_config_fuse,
	input  wire logic                 boot_done,
	input  wire logic                 debug_mode,
	input  wire logic                 timer_clear_instruction,
	output logic                      sys_reset_o,
	output logic                      irq_o
);
	import wwr_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic             aw_got;     // write address held
		logic [31:0]      aw_addr;    // held write address
		logic             w_got;      // write data held
		logic [7:0]       w_data;     // held low byte
		logic             w_lane;     // low byte strobe
		logic             bvalid;     // write answer pending
		logic [1:0]       bresp;      // write answer code
		logic             rvalid;     // read answer pending
		logic [7:0]       rdata;      // read byte
		logic [1:0]       rresp;      // read answer code
		logic             fuse_done;  // fuse caught after release
		logic             boot_seen;  // boot completion handled
		logic [7:0]       cfg;        // timeout_config as written
		logic [7:0]       cfg_act;    // copy in force on the slow side
		logic             lock;       // configuration lock
		logic             sync_pend;  // sync_pending flag
		logic [1:0]       sync_cnt;   // slow ticks into the transfer
		logic [2:0]       unl_cnt;    // unlock cycles left
		logic             clr_pend;   // clear being synchronised
		logic [1:0]       clr_cnt;    // slow ticks into the clear
		wwr_phase_e       phase;      // open or closed window
		logic [CNT_W-1:0] cnt;        // slow tick counter
		logic             sys_rst;    // reset pulse
		logic [IRQ_W-1:0] ist;        // sticky events
		logic [IRQ_W-1:0] imsk;       // event mask
	} wwr_state_s;

	wwr_state_s q;   // registered state
	wwr_state_s d;   // next state

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// slow ticks for a code; reserved codes clamp to the longest period
	function automatic logic [CNT_W-1:0] wwr_ticks(input logic [3:0] code);
		logic [3:0] c;
		c = (code > MAX_CODE) ? MAX_CODE : code;
		if (c == 4'h0) begin
			return {CNT_W{1'b0}};
		end
		return CNT_W'(BASE << (c - 4'h1));
	endfunction

	// address decode: bit 3 is hit, bits 2:0 the index
	function automatic logic [3:0] wwr_decode(input logic [31:0] addr);
		logic hit;
		hit = (addr[31:5] == 27'h000_0000) && (addr[4:2] <= LAST_IDX);
		return {hit, addr[4:2]};
	endfunction

	logic             tick;       // one pulse per slow clock rising edge
	logic [CNT_W-1:0] per_ticks;  // open or normal length
	logic [CNT_W-1:0] win_ticks;  // closed length
	logic [CNT_W-1:0] cnt_inc;    // counter plus one
	logic             run;        // watchdog counting
	logic             clr_apply;  // clear reaches the slow side now
	logic             expire;     // open period runs out now
	logic             closed_end; // closed window runs out now
	logic             wr_fire;    // register write performed now
	logic [3:0]       wr_dec;     // decoded write address
	logic [3:0]       rd_dec;     // decoded read address
	logic             unl_open;   // unlock window active
	logic             cfg_wr_ok;  // accepted config write
	logic [IRQ_W-1:0] ev;         // events this cycle

	// slow oscillator edge, two flops before any use
	wwr_tick_sync u_tick (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.ce      (ce),
		.async_i (slow_oscillator_clock),
		.rise_o  (tick)
	);

	// ----------------------------------------------------------------
	// decode of the current state
	// ----------------------------------------------------------------
	always_comb begin
		per_ticks  = wwr_ticks(q.cfg_act[PER_LSB +: 4]);
		win_ticks  = wwr_ticks(q.cfg_act[WIN_LSB +: 4]);
		cnt_inc    = q.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
		run        = q.fuse_done && (per_ticks != {CNT_W{1'b0}}) && !debug_mode;
		clr_apply  = run && tick && q.clr_pend && (q.clr_cnt == CLR_TICKS - 2'h1);
		expire     = run && tick && !clr_apply && (q.phase == PH_OPEN) && (cnt_inc >= per_ticks);
		closed_end = run && tick && !clr_apply && (q.phase == PH_CLOSED)
			&& (cnt_inc >= win_ticks);
		wr_fire    = q.aw_got && q.w_got && !q.bvalid;
		wr_dec     = wwr_decode(q.aw_addr);
		rd_dec     = wwr_decode(axi_req.araddr);
		unl_open   = (q.unl_cnt != 3'h0);
		cfg_wr_ok  = wr_fire && q.w_lane && wr_dec[3] && (wr_dec[2:0] == CFG_IDX)
			&& unl_open && !q.lock && !q.sync_pend;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		d         = q;
		ev        = {IRQ_W{1'b0}};
		d.sys_rst = 1'b0;

		// fuse capture on the first enabled cycle after release
		if (!q.fuse_done) begin
			d.fuse_done = 1'b1;
			d.cfg       = boot_config_fuse;
			d.cfg_act   = boot_config_fuse;
		end

		// boot completion locks a running watchdog
		if (boot_done && !q.boot_seen && q.fuse_done) begin
			d.boot_seen = 1'b1;
			if (q.cfg_act[PER_LSB +: 4] != 4'h0) begin
				d.lock = 1'b1;
			end
		end

		// unlock window runs down by itself
		if (unl_open) begin
			d.unl_cnt = q.unl_cnt - 3'h1;
		end

		// axi address and data channels, either order
		if (axi_req.awvalid && axi_rsp.awready) begin
			d.aw_got  = 1'b1;
			d.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && axi_rsp.wready) begin
			d.w_got  = 1'b1;
			d.w_data = axi_req.wdata[7:0];
			d.w_lane = axi_req.wstrb[0];
		end
		if (q.bvalid && axi_req.bready) begin
			d.bvalid = 1'b0;
		end

		// register write, answered one cycle later
		if (wr_fire) begin
			d.aw_got = 1'b0;
			d.w_got  = 1'b0;
			d.bvalid = 1'b1;
			d.bresp  = wr_dec[3] ? RESP_OKAY : RESP_SLVERR;
			if (wr_dec[3] && q.w_lane) begin
				case (wr_dec[2:0])
					CFG_IDX: begin
						// a write while busy or locked is dropped
						if (cfg_wr_ok) begin
							d.cfg       = q.w_data;
							d.sync_pend = 1'b1;
							d.sync_cnt  = 2'h0;
						end
						if (unl_open) begin
							d.unl_cnt = 3'h0;
						end
					end
					STAT_IDX: begin
						// sync_pending is read-only; the lock bit write needs prior unlock
						if (unl_open) begin
							d.unl_cnt = 3'h0;
							if (q.w_data[LOCK_BIT]) begin
								d.lock = 1'b1;
							end else if (debug_mode) begin
								d.lock = 1'b0;
							end
						end
					end
					IST_IDX: begin
						d.ist = q.ist & ~q.w_data[IRQ_W-1:0];
					end
					IMSK_IDX: begin
						d.imsk = q.w_data[IRQ_W-1:0];
					end
					KEY_IDX: begin
						if (q.w_data == UNLOCK_KEY) begin
							d.unl_cnt = UNLOCK_WIN_CYCLES;
						end
					end
					default: begin
						d.unl_cnt = d.unl_cnt;
					end
				endcase
			end
		end

		// read channel, data registered with the valid
		if (q.rvalid && axi_req.rready) begin
			d.rvalid = 1'b0;
		end
		if (axi_req.arvalid && axi_rsp.arready) begin
			d.rvalid = 1'b1;
			d.rresp  = rd_dec[3] ? RESP_OKAY : RESP_SLVERR;
			d.rdata  = 8'h00;
			if (rd_dec[3]) begin
				case (rd_dec[2:0])
					CFG_IDX:  d.rdata = q.cfg;
					STAT_IDX: d.rdata = {q.lock, 6'h00, q.sync_pend};
					IST_IDX:  d.rdata = {{(8-IRQ_W){1'b0}}, q.ist};
					IMSK_IDX: d.rdata = {{(8-IRQ_W){1'b0}}, q.imsk};
					default:  d.rdata = 8'h00;  // key reads as zero
				endcase
			end
		end

		// config transfer into the slow domain
		if (q.sync_pend && tick) begin
			if (q.sync_cnt == SYNC_TICKS - 2'h1) begin
				d.sync_pend = 1'b0;
				d.cfg_act   = q.cfg;
				ev[EV_SYNC] = 1'b1;
			end else begin
				d.sync_cnt = q.sync_cnt + 2'h1;
			end
		end

		// clear instruction capture; a repeat while pending is lost
		if (run && timer_clear_instruction && !q.clr_pend) begin
			d.clr_pend = 1'b1;
			d.clr_cnt  = 2'h0;
		end
		if (run && tick && q.clr_pend && !clr_apply) begin
			d.clr_cnt = q.clr_cnt + 2'h1;
		end

		// counter and window phase
		if (!run) begin
			d.cnt      = {CNT_W{1'b0}};
			d.phase    = PH_OPEN;
			d.clr_pend = 1'b0;
		end else if (clr_apply) begin
			d.clr_pend = 1'b0;
			d.cnt      = {CNT_W{1'b0}};
			if (q.phase == PH_CLOSED) begin
				d.sys_rst    = 1'b1;
				ev[EV_EARLY] = 1'b1;
				d.phase      = PH_OPEN;
			end else begin
				// closed window starts only after a clear
				d.phase = (win_ticks != {CNT_W{1'b0}}) ? PH_CLOSED : PH_OPEN;
			end
		end else if (closed_end) begin
			d.phase = PH_OPEN;
			d.cnt   = {CNT_W{1'b0}};
		end else if (expire) begin
			d.sys_rst      = 1'b1;
			ev[EV_TIMEOUT] = 1'b1;
			d.cnt          = {CNT_W{1'b0}};
			d.phase        = PH_OPEN;
		end else if (tick) begin
			d.cnt = cnt_inc;
		end

		// normal mode never stays in a closed window
		if (run && (win_ticks == {CNT_W{1'b0}}) && !closed_end) begin
			d.phase = PH_OPEN;
		end

		// events win over a clear in the same cycle
		d.ist = d.ist | ev;
	end

	// ----------------------------------------------------------------
	// registers, frozen while ce is low
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			q       <= '0;
			q.cfg   <= CFG_RESET;
			q.cfg_act <= CFG_RESET;
			q.lock  <= STAT_RESET[LOCK_BIT];
			q.phase <= PH_OPEN;
		end else if (ce) begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always_comb begin
		axi_rsp.awready = !q.aw_got && !q.bvalid;
		axi_rsp.wready  = !q.w_got && !q.bvalid;
		axi_rsp.bvalid  = q.bvalid;
		axi_rsp.bresp   = q.bresp;
		axi_rsp.arready = !q.rvalid;
		axi_rsp.rvalid  = q.rvalid;
		axi_rsp.rdata   = {24'h00_0000, q.rdata};
		axi_rsp.rresp   = q.rresp;
	end

	assign sys_reset_o = q.sys_rst;
	assign irq_o       = |(q.ist & q.imsk);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	lock_hold_a: assert property (ce && q.lock && !debug_mode |=> q.lock)
		else $error("lock cleared outside debug");
	cfg_locked_a: assert property (ce && q.fuse_done && q.lock |=> $stable(q.cfg))
		else $error("config changed while locked");
	cfg_unlock_a: assert property (ce && q.fuse_done && !unl_open |=> $stable(q.cfg))
		else $error("config changed without unlock");
	pend_set_a: assert property (ce && cfg_wr_ok |=> q.sync_pend && q.cfg == $past(q.w_data))
		else $error("pending not raised on config write");
	pend_clear_a: assert property ($fell(q.sync_pend) |-> q.cfg_act == q.cfg && q.ist[EV_SYNC])
		else $error("pending dropped before transfer");
	fuse_load_a: assert property (ce && !q.fuse_done |=> q.cfg == $past(boot_config_fuse))
		else $error("fuse value not loaded");
	boot_lock_a: assert property (ce && boot_done && !q.boot_seen && q.fuse_done
		&& q.cfg_act[3:0] != 4'h0 |=> q.lock)
		else $error("lock not set after boot");
	off_zero_a: assert property (ce && q.cfg_act[3:0] == 4'h0 |=> q.cnt == {CNT_W{1'b0}}
		&& !sys_reset_o)
		else $error("counter runs while disabled");
	expire_rst_a: assert property (ce && expire |=> sys_reset_o ##1 !sys_reset_o)
		else $error("no reset on expiry");
	early_rst_a: assert property (ce && clr_apply && q.phase == PH_CLOSED |=> sys_reset_o
		&& q.ist[EV_EARLY])
		else $error("no reset on early clear");
	first_win_a: assert property (ce && clr_apply && q.phase == PH_OPEN
		&& win_ticks != {CNT_W{1'b0}} |=> q.phase == PH_CLOSED && !sys_reset_o)
		else $error("closed window not started by clear");
	closed_end_a: assert property (ce && closed_end |=> q.phase == PH_OPEN
		&& q.cnt == {CNT_W{1'b0}})
		else $error("closed window did not open");
	normal_mode_a: assert property (ce && run && win_ticks == {CNT_W{1'b0}}
		|=> q.phase == PH_OPEN)
		else $error("closed phase in normal mode");
	clr_ignore_a: assert property (ce && run && q.clr_pend && !clr_apply
		&& timer_clear_instruction |=> q.clr_cnt >= $past(q.clr_cnt))
		else $error("repeated clear restarted sync");
	irq_level_a: assert property (ce && |(ev & q.imsk) && !wr_fire |=> irq_o)
		else $error("masked-in event gave no interrupt");

endmodule

// ### wwr_watchdog_tb.sv
// self-checking bench for the windowed watchdog block
`timescale 1ns/1ps
module wwr_watchdog_tb;
	import wwr_pkg::*;

	// --------------------------------------------------------------
	// stimulus, observed outputs and bookkeeping
	// --------------------------------------------------------------
	logic         ref_clk;          // 25 MHz system clock
	logic         arst_n;           // async reset, active low
	logic         slow_clk;         // stand-in slow oscillator
	logic         boot_done;        // boot completion level
	logic         debug_mode;       // debug halt level
	logic         clr_p;            // clear instruction pulse
	logic         rst_o;            // watchdog reset request
	logic         irq;              // interrupt level
	wwr_axi_req_s req;              // bus master side
	wwr_axi_rsp_s rsp;              // bus slave side
	int           err_total   = 0;  // mismatches
	int           comparisons = 0;  // compares made
	int           cyc         = 0;  // hang guard count
	int           rst_seen    = 0;  // reset pulses seen
	int           base;             // pulse count snapshot
	logic [31:0]  rd;               // last read data
	logic [1:0]   resp;             // last response code

	// code one is two slow ticks, so periods stay short
	wwr_watchdog #(.BASE(15'h0002)) u_dut (
		.ref_clk                 (ref_clk),
		.arst_n                  (arst_n),
		.ce                      (1'b1),
		.axi_req                 (req),
		.axi_rsp                 (rsp),
		.slow_oscillator_clock   (slow_clk),
		.boot_config_fuse        (8'h13),
		.boot_done               (boot_done),
		.debug_mode              (debug_mode),
		.timer_clear_instruction (clr_p),
		.sys_reset_o             (rst_o),
		.irq_o                   (irq)
	);

	// --------------------------------------------------------------
	// clocks: slow clock is 16 system cycles, far above the minimum
	// --------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	initial begin
		slow_clk = 1'b0;
		forever #320 slow_clk = ~slow_clk;
	end

	// count reset pulses; one-cycle pulses must not be missed
	always @(posedge ref_clk) begin
		if (rst_o === 1'b1) begin
			rst_seen <= rst_seen + 1;
		end
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_total++;
			wrap_up();
		end
	end

	// --------------------------------------------------------------
	// tasks
	// --------------------------------------------------------------
	// verdict and end of run
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// compare a byte against a full bus word, upper bits must be zero
	task automatic chk(input string nm, input logic [7:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== {24'h00_0000, e}) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask

	// bus write: address and data offered together, each dropped when taken
	task automatic wr(input logic [2:0] idx, input logic [7:0] d);
		logic a;
		logic w;
		a = 1'b1;
		w = 1'b1;
		req.awvalid <= 1'b1;
		req.awaddr  <= {27'h000_0000, idx, 2'b00};
		req.wvalid  <= 1'b1;
		req.wdata   <= {24'h00_0000, d};
		while (a || w) begin
			@(posedge ref_clk);
			if (a && rsp.awready === 1'b1) begin
				a = 1'b0;
				req.awvalid <= 1'b0;
			end
			if (w && rsp.wready === 1'b1) begin
				w = 1'b0;
				req.wvalid <= 1'b0;
			end
		end
		// bready is held high, so the answer is taken where it is seen
		while (rsp.bvalid !== 1'b1) @(posedge ref_clk);
		resp = rsp.bresp;
	endtask

	// bus read, rready held high
	task automatic rdr(input logic [2:0] idx);
		req.arvalid <= 1'b1;
		req.araddr  <= {27'h000_0000, idx, 2'b00};
		do @(posedge ref_clk); while (rsp.arready !== 1'b1);
		req.arvalid <= 1'b0;
		do @(posedge ref_clk); while (rsp.rvalid !== 1'b1);
		rd   = rsp.rdata;
		resp = rsp.rresp;
	endtask

	// key write then the protected write, back to back to fit the window
	task automatic pwr(input logic [2:0] idx, input logic [7:0] d);
		wr(KEY_IDX, UNLOCK_KEY);
		wr(idx, d);
	endtask

	// protected config write, then wait out the domain crossing
	task automatic set_cfg(input logic [7:0] d);
		pwr(CFG_IDX, d);
		rdr(STAT_IDX);
		chk("pending set", 8'h01, rd);
		for (int i = 0; i < 100 && rd[0] === 1'b1; i++) rdr(STAT_IDX);
		chk("pending cleared", 8'h00, rd);
		rdr(CFG_IDX);
		chk("config value", d, rd);
	endtask

	// one-cycle clear instruction
	task automatic clr;
		clr_p <= 1'b1;
		@(posedge ref_clk);
		clr_p <= 1'b0;
	endtask

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		arst_n      = 1'b0;
		boot_done   = 1'b0;
		debug_mode  = 1'b0;
		clr_p       = 1'b0;
		req         = '0;
		req.wstrb   = 4'hF;
		req.bready  = 1'b1;
		req.rready  = 1'b1;
		repeat (12) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge ref_clk);

		// boot: fuse value, then lock once boot completes
		rdr(CFG_IDX);
		chk("fuse config", 8'h13, rd);
		rdr(STAT_IDX);
		chk("status at boot", STAT_RESET, rd);
		boot_done <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rdr(STAT_IDX);
		chk("auto lock", 8'h80, rd);
		$display("test boot done");

		// lock protection and release only in debug
		pwr(CFG_IDX, 8'h05);
		rdr(CFG_IDX);
		chk("locked config", 8'h13, rd);
		pwr(STAT_IDX, 8'h00);
		rdr(STAT_IDX);
		chk("lock kept", 8'h80, rd);
		debug_mode <= 1'b1;
		@(posedge ref_clk);
		pwr(STAT_IDX, 8'h00);
		rdr(STAT_IDX);
		chk("lock cleared", 8'h00, rd);
		debug_mode <= 1'b0;
		wr(CFG_IDX, 8'h05);
		rdr(CFG_IDX);
		chk("unprotected write", 8'h13, rd);
		$display("test lock done");

		// sync event raises the interrupt, write one clears it
		wr(IMSK_IDX, 8'h04);
		wr(IST_IDX, 8'h07);
		set_cfg(8'h02);
		chk("irq on", 8'h01, {31'h0000_0000, irq});
		wr(IST_IDX, 8'h04);
		@(posedge ref_clk);
		chk("irq off", 8'h00, {31'h0000_0000, irq});
		rdr(3'h5);
		chk("unmapped read", {6'h00, RESP_SLVERR}, {30'h0000_0000, resp});
		wr(3'h5, 8'hFF);
		chk("unmapped write", {6'h00, RESP_SLVERR}, {30'h0000_0000, resp});
		$display("test sync done");

		// normal mode: regular clears hold it off, silence expires
		set_cfg(8'h04);
		wr(IST_IDX, 8'h03);
		clr();
		repeat (64) @(posedge ref_clk);
		base = rst_seen;
		repeat (10) begin
			clr();
			repeat (63) @(posedge ref_clk);
		end
		chk("no expiry while cleared", 8'h00, rst_seen - base);
		repeat (400) @(posedge ref_clk);
		chk("single expiry", 8'h01, rst_seen - base);
		rdr(IST_IDX);
		chk("expiry event", 8'h01, rd & 32'h0000_0003);
		$display("test normal done");

		// window mode: first clear starts the closed window, a repeat in sync is dropped,
		// a clear inside the closed window resets
		clr();
		repeat (48) @(posedge ref_clk);
		set_cfg(8'h34);
		wr(IST_IDX, 8'h03);
		base = rst_seen;
		clr();
		repeat (4) @(posedge ref_clk);
		clr();
		repeat (60) @(posedge ref_clk);
		chk("first clear accepted", 8'h00, rst_seen - base);
		clr();
		repeat (100) @(posedge ref_clk);
		chk("early clear reset", 8'h01, rst_seen - base);
		rdr(IST_IDX);
		chk("early event", 8'h02, rd & 32'h0000_0003);
		$display("test window done");

		// period code zero: watchdog stays quiet
		set_cfg(8'h00);
		base = rst_seen;
		repeat (600) @(posedge ref_clk);
		chk("disabled quiet", 8'h00, rst_seen - base);
		$display("test disable done");
		wrap_up();
	end
endmodule
